// [src/fiap_ctrl.sv]
/*
  Flash self-programming controller: the register block reached by the
  CPU through external-memory accesses, the operation sequencer that
  drives the embedded flash array, CPU hold and stall, and the RAM
  execution remap decode.
  Assumes a flash array that returns read data in the same cycle as its read
  strobe and that performs program and erase while its level strobes
  stand; external_memory_space_wr and external_memory_space_rd are single-cycle strobes.
*/
`include "fiap_defines.svh"

module fiap_ctrl
  import fiap_pkg::*;
#(
  parameter int CYC_PER_US = `FIAP_CYC_PER_US,
  parameter int PROG_US = `FIAP_PROG_TIME_US,
  parameter int ERASE_US = `FIAP_ERASE_TIME_US
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // CPU external-memory register access
  input wire logic [15:0] external_memory_space_addr,
  input wire logic external_memory_space_wr,
  input wire logic external_memory_space_rd,
  input wire logic [7:0] external_memory_space_wdata,
  output logic [7:0] external_memory_space_rdata_q,
  // CPU program fetch remap
  input wire logic [15:0] prog_addr,
  output logic prog_from_xram_q,
  // CPU control
  output logic cpu_hold_in_reset_q,
  output logic cpu_stall_q,
  // Embedded flash array
  output logic [12:0] flash_address_bits_q,
  output logic [7:0] flash_wdata_q,
  input wire logic [7:0] flash_rdata,
  output logic flash_read_en_q,
  output logic flash_prog_en_q,
  output logic flash_sector_erase_q,
  output logic flash_mass_erase_q,
  output logic flash_info_sel_q,
  output logic flash_trim_sel_q,
  output logic [1:0] flash_timing_sel_q
);

  ////////////////////////////////////////////////////////////////////////
  // State

  fiap_state_e state_q;
  fiap_state_e state_d;
  logic [7:0] remap_q;
  logic [7:0] addr_lo_q;
  logic [7:0] addr_hi_q;
  logic [7:0] data_q;
  logic [7:0] guard_q;
  logic hold_q;
  logic address_auto_increment_q;
  logic serase_q;
  logic merase_q;
  logic info_q;
  logic busy_q;
  logic busy_d;

  ////////////////////////////////////////////////////////////////////////
  // Register decode

  logic sel_remap;
  logic sel_ctrl;
  logic sel_addr_lo;
  logic sel_addr_hi;
  logic sel_data;
  logic sel_guard;
  logic idle;
  logic wr_ctrl;
  logic wr_addr;
  logic wr_data;

  assign sel_remap = external_memory_space_addr == `FIAP_OFS_REMAP;
  assign sel_ctrl = external_memory_space_addr == `FIAP_OFS_CTRL;
  assign sel_addr_lo = external_memory_space_addr == `FIAP_OFS_ADDR_LO;
  assign sel_addr_hi = external_memory_space_addr == `FIAP_OFS_ADDR_HI;
  assign sel_data = external_memory_space_addr == `FIAP_OFS_DATA;
  assign sel_guard = external_memory_space_addr == `FIAP_OFS_GUARD;
  assign idle = state_q == FIAP_ST_IDLE;
  assign wr_ctrl = external_memory_space_wr && sel_ctrl;
  // Address and data are frozen while an access is under way
  assign wr_addr = external_memory_space_wr && idle;
  assign wr_data = external_memory_space_wr && sel_data && idle;

  ////////////////////////////////////////////////////////////////////////
  // Launch decisions

  logic key_ok;
  logic req_read;
  logic req_start;
  logic launch_read;
  logic launch_op;
  logic op_serase;
  logic op_merase;
  logic op_prog;
  logic op_long;
  logic op_done;
  logic capt_done;
  logic access_end;
  fiap_addr_t cur_addr;
  fiap_addr_t next_addr;

  assign key_ok = guard_q == `FIAP_GUARD_KEY;
  assign req_read = wr_ctrl && idle && external_memory_space_wdata[`FIAP_CTRL_READ];
  assign req_start = wr_ctrl && idle && external_memory_space_wdata[`FIAP_CTRL_START];
  assign launch_read = req_read;
  // Trim sector may never be programmed or erased; keyless start is dropped
  assign launch_op = req_start && !req_read && key_ok &&
                     !addr_hi_q[`FIAP_AH_TRIM];
  assign op_serase = external_memory_space_wdata[`FIAP_CTRL_SERASE];
  assign op_merase = external_memory_space_wdata[`FIAP_CTRL_MERASE];
  assign op_prog = !op_serase && !op_merase;
  assign op_long = !op_prog;
  assign capt_done = state_q == FIAP_ST_CAPT;
  assign access_end = capt_done ||
                      (op_done && flash_prog_en_q);
  assign cur_addr = {addr_hi_q[`FIAP_AH_ADDR_HI:0], addr_lo_q};
  assign next_addr = cur_addr + 13'h0001;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      FIAP_ST_IDLE: begin
        if (launch_read) begin
          state_d = FIAP_ST_CAPT;
        end else if (launch_op) begin
          state_d = FIAP_ST_OP;
        end
      end
      FIAP_ST_CAPT: begin
        state_d = FIAP_ST_IDLE;
      end
      FIAP_ST_OP: begin
        if (op_done) begin
          state_d = FIAP_ST_IDLE;
        end
      end
      default: begin
        state_d = FIAP_ST_IDLE;
      end
    endcase
  end

  // Busy covers the read fetch and the whole timed operation
  assign busy_d = (state_d != FIAP_ST_IDLE);

  fiap_op_timer #(
    .CYC_PER_US(CYC_PER_US),
    .PROG_US(PROG_US),
    .ERASE_US(ERASE_US),
    .CNT_W(20)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(launch_op && idle),
    .long_op(op_long),
    .done(op_done)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= FIAP_ST_IDLE;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      remap_q <= `FIAP_RST_BYTE;
      guard_q <= `FIAP_RST_BYTE;
    end else if (external_memory_space_wr) begin
      if (sel_remap) begin
        remap_q <= external_memory_space_wdata;
      end
      if (sel_guard) begin
        guard_q <= external_memory_space_wdata;
      end
    end
  end

  // Hold and auto-increment stay writable during an operation
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hold_q <= 1'b0;
      address_auto_increment_q <= 1'b0;
    end else if (wr_ctrl) begin
      hold_q <= external_memory_space_wdata[`FIAP_CTRL_HOLD];
      address_auto_increment_q <= external_memory_space_wdata[`FIAP_CTRL_ADDRESS_AUTO_INCREMENT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serase_q <= 1'b0;
      merase_q <= 1'b0;
      info_q <= 1'b0;
    end else if (wr_ctrl && idle) begin
      serase_q <= external_memory_space_wdata[`FIAP_CTRL_SERASE];
      merase_q <= external_memory_space_wdata[`FIAP_CTRL_MERASE];
      info_q <= external_memory_space_wdata[`FIAP_CTRL_INFO];
    end
  end

  // Pointer: software writes, else auto-increment after each read or program
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_lo_q <= `FIAP_RST_BYTE;
      addr_hi_q <= `FIAP_RST_BYTE;
    end else if (wr_addr && sel_addr_lo) begin
      addr_lo_q <= external_memory_space_wdata;
    end else if (wr_addr && sel_addr_hi) begin
      addr_hi_q <= external_memory_space_wdata;
    end else if (access_end && address_auto_increment_q) begin
      addr_lo_q <= next_addr[7:0];
      addr_hi_q[`FIAP_AH_ADDR_HI:0] <= next_addr[12:8];
    end
  end

  // Fetched byte wins over nothing: CPU data writes are blocked in CAPT
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_q <= `FIAP_RST_BYTE;
    end else if (capt_done) begin
      data_q <= flash_rdata;
    end else if (wr_data) begin
      data_q <= external_memory_space_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-back

  logic [7:0] ctrl_view;
  logic [7:0] rd_mux;

  // Start and read are self-clearing strobes and read as zero
  assign ctrl_view = {hold_q, address_auto_increment_q, busy_q, 1'b0,
                      serase_q, merase_q, info_q, 1'b0};

  always_comb begin
    rd_mux = 8'h00;
    if (sel_remap) begin
      rd_mux = remap_q;
    end else if (sel_ctrl) begin
      rd_mux = ctrl_view;
    end else if (sel_addr_lo) begin
      rd_mux = addr_lo_q;
    end else if (sel_addr_hi) begin
      rd_mux = addr_hi_q;
    end else if (sel_data) begin
      rd_mux = data_q;
    end else if (sel_guard) begin
      rd_mux = guard_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      external_memory_space_rdata_q <= 8'h00;
    end else if (external_memory_space_rd) begin
      external_memory_space_rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU control and program remap

  logic remap_on;
  logic in_window;

  assign remap_on = remap_q[`FIAP_REMAP_EN];
  assign in_window = (prog_addr >= `FIAP_REMAP_LO) &&
                     (prog_addr <= `FIAP_REMAP_HI);

  // Stall for the whole program or erase, unless RAM execution remap is on
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_hold_in_reset_q <= 1'b0;
      cpu_stall_q <= 1'b0;
      prog_from_xram_q <= 1'b0;
    end else begin
      cpu_hold_in_reset_q <= hold_q;
      cpu_stall_q <= (state_d == FIAP_ST_OP) && !remap_on;
      prog_from_xram_q <= remap_on && in_window;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash array strobes

  logic start_prog;
  logic start_serase;
  logic start_merase;

  assign start_prog = launch_op && op_prog;
  assign start_serase = launch_op && op_serase;
  assign start_merase = launch_op && op_merase && !op_serase;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flash_read_en_q <= 1'b0;
      flash_prog_en_q <= 1'b0;
      flash_sector_erase_q <= 1'b0;
      flash_mass_erase_q <= 1'b0;
    end else begin
      flash_read_en_q <= launch_read;
      if (op_done) begin
        flash_prog_en_q <= 1'b0;
        flash_sector_erase_q <= 1'b0;
        flash_mass_erase_q <= 1'b0;
      end else if (idle) begin
        flash_prog_en_q <= start_prog;
        flash_sector_erase_q <= start_serase;
        flash_mass_erase_q <= start_merase;
      end
    end
  end

  // Target selects latch at launch and stand for the whole access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flash_address_bits_q <= 13'h0000;
      flash_wdata_q <= 8'h00;
      flash_info_sel_q <= 1'b0;
      flash_trim_sel_q <= 1'b0;
      flash_timing_sel_q <= 2'h0;
    end else if (launch_read || launch_op) begin
      flash_address_bits_q <= cur_addr;
      flash_wdata_q <= data_q;
      flash_info_sel_q <= external_memory_space_wdata[`FIAP_CTRL_INFO];
      flash_trim_sel_q <= addr_hi_q[`FIAP_AH_TRIM] && launch_read;
      flash_timing_sel_q <= addr_hi_q[`FIAP_AH_TIM_HI:`FIAP_AH_TIM_LO];
    end
  end

endmodule

// [src/fiap_defines.svh]
/*
  Offsets, field positions, reset values and timing figures of the
  flash self-programming controller.
  Assumes an 8-bit external-memory register bus and a 125 MHz clock.
*/
`ifndef FIAP_DEFINES_SVH
`define FIAP_DEFINES_SVH

// Register offsets in the external memory space
`define FIAP_OFS_REMAP 16'hFF00
`define FIAP_OFS_CTRL 16'hFF20
`define FIAP_OFS_ADDR_LO 16'hFF21
`define FIAP_OFS_ADDR_HI 16'hFF22
`define FIAP_OFS_DATA 16'hFF23
`define FIAP_OFS_GUARD 16'hFF24

// flash_op_control fields
`define FIAP_CTRL_HOLD 7
`define FIAP_CTRL_ADDRESS_AUTO_INCREMENT 6
`define FIAP_CTRL_BUSY 5
`define FIAP_CTRL_READ 4
`define FIAP_CTRL_SERASE 3
`define FIAP_CTRL_MERASE 2
`define FIAP_CTRL_INFO 1
`define FIAP_CTRL_START 0

// flash_addr_high_timing fields
`define FIAP_AH_TRIM 7
`define FIAP_AH_TIM_HI 6
`define FIAP_AH_TIM_LO 5
`define FIAP_AH_ADDR_HI 4

// ram_exec_remap_control field and remapped window
`define FIAP_REMAP_EN 0
`define FIAP_REMAP_LO 16'h0010
`define FIAP_REMAP_HI 16'h00FF

// Reset values and guard key
`define FIAP_RST_BYTE 8'h00
`define FIAP_GUARD_KEY 8'hA5

// Timing: clock rate, operation lengths in microseconds
`define FIAP_CLK_MHZ 125
`define FIAP_PROG_TIME_US 100
`define FIAP_ERASE_TIME_US 100000
`define FIAP_CYC_PER_US (`FIAP_CLK_MHZ * 1)

`endif

// [src/fiap_pkg.sv]
/*
  Types shared by the flash self-programming controller.
  Assumes fiap_defines.svh supplies the numeric constants.
*/
package fiap_pkg;

  typedef enum logic [1:0] {
    FIAP_ST_IDLE = 2'b00,
    FIAP_ST_CAPT = 2'b01,
    FIAP_ST_OP   = 2'b10
  } fiap_state_e;

  typedef logic [12:0] fiap_addr_t;

endpackage

// [src/fiap_op_timer.sv]
/*
  Operation timer: a microsecond enable divider and a tick counter
  that times one program or erase operation.
  Assumes start is a one-cycle pulse issued only while not running.
*/
`include "fiap_defines.svh"

module fiap_op_timer
  import fiap_pkg::*;
#(
  parameter int CYC_PER_US = `FIAP_CYC_PER_US,
  parameter int PROG_US = `FIAP_PROG_TIME_US,
  parameter int ERASE_US = `FIAP_ERASE_TIME_US,
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic long_op,
  // Status
  output logic done
);

  if (CYC_PER_US < 1 || PROG_US < 1 || ERASE_US < 1 ||
      ERASE_US >= (1 << CNT_W) || PROG_US >= (1 << CNT_W) ||
      CYC_PER_US >= (1 << 16)) begin : g_check
    $error("fiap_op_timer: unsupported timing parameters");
  end

  logic run_q;
  logic run_d;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [CNT_W-1:0] ticks_q;
  logic [CNT_W-1:0] ticks_d;
  logic [CNT_W-1:0] limit_q;
  logic us_tick;
  logic last_tick;

  ////////////////////////////////////////////////////////////////////////
  // One-cycle enable each microsecond, only while an operation runs
  assign us_tick = run_q && (div_q == 16'(CYC_PER_US - 1));
  assign div_d = (!run_q || us_tick) ? 16'h0000 : div_q + 16'h0001;
  assign last_tick = us_tick && (ticks_q == limit_q);
  assign ticks_d = start ? {CNT_W{1'b0}} :
                   us_tick ? ticks_q + CNT_W'(1) : ticks_q;
  assign run_d = start ? 1'b1 : (last_tick ? 1'b0 : run_q);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      run_q <= 1'b0;
      div_q <= 16'h0000;
      ticks_q <= {CNT_W{1'b0}};
      limit_q <= {CNT_W{1'b0}};
      done <= 1'b0;
    end else begin
      run_q <= run_d;
      div_q <= div_d;
      ticks_q <= ticks_d;
      done <= last_tick;
      if (start) begin
        limit_q <= long_op ? CNT_W'(ERASE_US - 1) : CNT_W'(PROG_US - 1);
      end
    end
  end

endmodule

// [tb/fiap_flash_model.sv]
/*
  Behavioural flash array with main, info and trim sectors.
  Assumes the controller's registered strobes on sys_clk.
*/
module fiap_flash_model (
  // Clock
  input wire logic sys_clk,
  // Controller side
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  input wire logic read_en,
  input wire logic prog_en,
  input wire logic serase,
  input wire logic merase,
  input wire logic info_sel,
  input wire logic trim_sel,
  // Read data
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8192];
  logic [7:0] info [128];
  logic prog_p;
  logic ers_p;
  logic [7:0] junk_q;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    foreach (info[i]) info[i] = 8'hFF;
    junk_q = 8'h00;
  end
  // Unclocked array read: data stands while the read strobe does,
  // since the controller captures it at the edge ending the strobe
  // Idle cycles toggle so a late sample cannot match
  assign rdata = !read_en ? junk_q :
                 trim_sel ? 8'hC3 ^ addr[7:0] :
                 info_sel ? info[addr[6:0]] : mem[addr];
  ////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    prog_p <= prog_en;
    ers_p <= serase | merase;
    junk_q <= ~junk_q;
    if (prog_en && !prog_p && info_sel)
      info[addr[6:0]] <= wdata;
    if (prog_en && !prog_p && !info_sel)
      mem[addr] <= wdata;
    if (serase && !ers_p) begin
      for (int i = 0; i < 2048; i++)
        if (!info_sel) mem[{addr[12:11], i[10:0]}] <= 8'hFF;
      if (info_sel) foreach (info[i]) info[i] <= 8'hFF;
    end
    if (merase && !ers_p) begin
      foreach (mem[i]) mem[i] <= 8'hFF;
      if (info_sel) foreach (info[i]) info[i] <= 8'hFF;
    end
  end
endmodule

// [tb/fiap_ctrl_asserts.sv]
/*
  Port-level checks of the flash controller.
  Assumes binding to fiap_ctrl with its timer parameters.
*/
module fiap_ctrl_asserts #(
  parameter int CYC_PER_US = 125,
  parameter int PROG_US = 100,
  parameter int ERASE_US = 100000
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] external_memory_space_addr,
  input wire logic external_memory_space_wr,
  input wire logic external_memory_space_rd,
  input wire logic [7:0] external_memory_space_wdata,
  input wire logic [7:0] external_memory_space_rdata_q,
  input wire logic [15:0] prog_addr,
  input wire logic prog_from_xram_q,
  input wire logic cpu_hold_in_reset_q,
  input wire logic cpu_stall_q,
  input wire logic flash_read_en_q,
  input wire logic flash_prog_en_q,
  input wire logic flash_sector_erase_q,
  input wire logic flash_mass_erase_q,
  input wire logic flash_info_sel_q,
  input wire logic [1:0] flash_timing_sel_q
);
  logic [7:0] guard_q, ah_q, remap_q;
  logic [31:0] cnt_q;
  logic long_q;
  wire op = flash_prog_en_q | flash_sector_erase_q | flash_mass_erase_q;
  wire busy = op | flash_read_en_q;
  wire wr_ctl = external_memory_space_wr && external_memory_space_addr == 16'hFF20;
  wire go = wr_ctl && external_memory_space_wdata[0] && !external_memory_space_wdata[4] && !busy;
  wire go_ok = go && guard_q == 8'hA5 && !ah_q[7];
  wire hit = remap_q[0] && prog_addr >= 16'h0010 && prog_addr <= 16'h00FF;
  wire [31:0] lim = long_q ? ERASE_US * CYC_PER_US : PROG_US * CYC_PER_US;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      guard_q <= 8'h00;
      ah_q <= 8'h00;
      remap_q <= 8'h00;
      cnt_q <= 32'h0;
      long_q <= 1'b0;
    end else begin
      if (external_memory_space_wr && external_memory_space_addr == 16'hFF24) guard_q <= external_memory_space_wdata;
      if (external_memory_space_wr && external_memory_space_addr == 16'hFF00) remap_q <= external_memory_space_wdata;
      if (external_memory_space_wr && external_memory_space_addr == 16'hFF22 && !busy) ah_q <= external_memory_space_wdata;
      cnt_q <= op ? cnt_q + 32'h1 : 32'h0;
      if (op) long_q <= !flash_prog_en_q;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  key_refuse_a: assert property (go && !go_ok |=> !op)
    else $error("start taken without key");
  hold_bit_a: assert property (wr_ctl |-> ##2
    cpu_hold_in_reset_q == $past(external_memory_space_wdata[7], 2)) else $error("hold bit");
  prog_go_a: assert property (go_ok && external_memory_space_wdata[3:2] == 2'b00 |=>
    flash_prog_en_q && !flash_sector_erase_q) else $error("no program");
  serase_go_a: assert property (go_ok && external_memory_space_wdata[3] |=>
    flash_sector_erase_q && flash_info_sel_q == $past(external_memory_space_wdata[1]))
    else $error("no sector erase");
  merase_go_a: assert property (go_ok && external_memory_space_wdata[3:2] == 2'b01 |=>
    flash_mass_erase_q && !flash_sector_erase_q) else $error("no mass erase");
  timing_sel_a: assert property (go_ok |=>
    flash_timing_sel_q == $past(ah_q[6:5])) else $error("timing select");
  busy_read_a: assert property (external_memory_space_rd && external_memory_space_addr == 16'hFF20 |=>
    external_memory_space_rdata_q[5] == $past(busy) && !external_memory_space_rdata_q[4] && !external_memory_space_rdata_q[0])
    else $error("busy bit read");
  cpu_stall_a: assert property (cpu_stall_q == (op && !remap_q[0]))
    else $error("stall wrong");
  remap_hit_a: assert property (1'b1 |=>
    prog_from_xram_q == $past(hit)) else $error("remap decode");
  op_len_a: assert property ($fell(op) |->
    cnt_q >= lim && cnt_q <= lim + 32'd3) else $error("op length");
  read_go_a: assert property (wr_ctl && external_memory_space_wdata[4] && !busy |=>
    flash_read_en_q ##1 !flash_read_en_q) else $error("read strobe");
  cover property (go_ok ##1 flash_prog_en_q);
  cover property (go_ok ##1 flash_sector_erase_q);
  cover property (go_ok ##1 flash_mass_erase_q);
  cover property ($fell(flash_read_en_q));
endmodule

// [tb/tb.sv]
/*
  Self-checking bench of the flash controller.
  Assumes the flash model and checker compile first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, external_memory_space_wr, external_memory_space_rd, hold, stall, xram;
  logic rd_en, pg_en, se_en, me_en, info, trim, bs;
  logic [15:0] external_memory_space_addr, prog_addr;
  logic [7:0] external_memory_space_wdata, rdata, frd, fwd, v, bz;
  logic [12:0] fa;
  logic [1:0] tsel;
  int miscompares, total_checks;
  // Short timer values keep erase runs brief
  fiap_ctrl #(.CYC_PER_US(2), .PROG_US(3), .ERASE_US(5)) fiap_ctrl_i (
    .sys_clk(sys_clk), .reset(reset), .external_memory_space_addr(external_memory_space_addr),
    .external_memory_space_wr(external_memory_space_wr), .external_memory_space_rd(external_memory_space_rd), .external_memory_space_wdata(external_memory_space_wdata),
    .external_memory_space_rdata_q(rdata), .prog_addr(prog_addr), .prog_from_xram_q(xram),
    .cpu_hold_in_reset_q(hold), .cpu_stall_q(stall),
    .flash_address_bits_q(fa), .flash_wdata_q(fwd), .flash_rdata(frd),
    .flash_read_en_q(rd_en), .flash_prog_en_q(pg_en),
    .flash_sector_erase_q(se_en), .flash_mass_erase_q(me_en),
    .flash_info_sel_q(info), .flash_trim_sel_q(trim),
    .flash_timing_sel_q(tsel));
  fiap_flash_model fiap_flash_model_i (.sys_clk(sys_clk), .addr(fa),
    .wdata(fwd), .read_en(rd_en), .prog_en(pg_en), .serase(se_en),
    .merase(me_en), .info_sel(info), .trim_sel(trim), .rdata(frd));
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] m(input logic [12:0] a);
    return fiap_flash_model_i.mem[a];
  endfunction
  function automatic logic [7:0] fi(input logic [6:0] a);
    return fiap_flash_model_i.info[a];
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    external_memory_space_wr <= 1'b1;
    external_memory_space_addr <= a;
    external_memory_space_wdata <= d;
    @(posedge sys_clk);
    external_memory_space_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk);
    external_memory_space_rd <= 1'b1;
    external_memory_space_addr <= a;
    @(posedge sys_clk);
    external_memory_space_rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(16'hFF20);
      n++;
    end while (v[5] !== 1'b0 && n < 100);
    if (n >= 100) begin
      miscompares++;
      summarize();
    end
  endtask
  // Loads address and data, starts, samples busy and stall once
  task automatic op(input logic [15:0] a, input logic [7:0] d, c);
    wr(16'hFF21, a[7:0]);
    wr(16'hFF22, a[15:8]);
    wr(16'hFF23, d);
    wr(16'hFF20, c);
    rd(16'hFF20);
    bz = v;
    bs = stall;
    idle();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] a [7] = '{16'hFF00, 16'hFF20, 16'hFF21, 16'hFF22,
      16'hFF23, 16'hFF24, 16'hFF25};
    foreach (a[i]) begin
      rd(a[i]);
      check(v, 8'h00);
    end
    wr(16'hFF30, 8'h55);
    rd(16'hFF30);
    check(v, 8'h00);
    wr(16'hFF20, 8'h20);
    rd(16'hFF20);
    check(v, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_prog();
    op(16'h0123, 8'h3C, 8'h01);
    check(bz, 8'h00);
    check(m(13'h0123), 8'hFF);
    wr(16'hFF24, 8'hA5);
    op(16'h1234, 8'h5A, 8'h01);
    check(bz, 8'h20);
    check({7'h0, bs}, 8'h01);
    check(m(13'h1234), 8'h5A);
    op(16'h1234, 8'h00, 8'h10);
    rd(16'hFF23);
    check(v, 8'h5A);
    for (int t = 0; t < 3; t++) begin
      op({1'b0, t[1:0], 13'h0240}, 8'h10 + t[7:0], 8'h01);
      check(m(13'h0240), 8'h10 + t[7:0]);
      check({6'h00, tsel}, {6'h00, t[1:0]});
    end
    $display("test program done");
  endtask
  task automatic t_remap();
    wr(16'hFF00, 8'h01);
    @(posedge sys_clk);
    prog_addr <= 16'h0010;
    op(16'h0300, 8'h66, 8'h01);
    check({7'h0, bs}, 8'h00);
    check({7'h0, xram}, 8'h01);
    @(posedge sys_clk);
    prog_addr <= 16'h0100;
    repeat (2) @(posedge sys_clk);
    #1 check({7'h0, xram}, 8'h00);
    wr(16'hFF00, 8'h00);
    $display("test remap done");
  endtask
  task automatic t_auto();
    op(16'h20FF, 8'h00, 8'h50);
    rd(16'hFF21);
    check(v, 8'h00);
    rd(16'hFF22);
    check(v, 8'h21);
    wr(16'hFF23, 8'h77);
    wr(16'hFF20, 8'h41);
    idle();
    check(m(13'h0100), 8'h77);
    rd(16'hFF21);
    check(v, 8'h01);
    wr(16'hFF20, 8'h00);
    $display("test address_auto_increment done");
  endtask
  task automatic t_erase();
    op(16'h0800, 8'h12, 8'h01);
    op(16'h1000, 8'h34, 8'h01);
    op(16'h0800, 8'h00, 8'h09);
    check(bz, 8'h28);
    check(m(13'h0800), 8'hFF);
    check(m(13'h1000), 8'h34);
    op(16'h0005, 8'h56, 8'h03);
    check(fi(7'h05), 8'h56);
    check(m(13'h0005), 8'hFF);
    op(16'h0000, 8'h00, 8'h0B);
    check(fi(7'h05), 8'hFF);
    check(m(13'h1000), 8'h34);
    for (int i = 0; i < 16; i++)
      op({8'h00, i[7:0]}, 8'hFF, 8'h03);
    op(16'h0005, 8'h56, 8'h03);
    op(16'h0000, 8'h00, 8'h05);
    check(m(13'h1000), 8'hFF);
    check(fi(7'h05), 8'h56);
    op(16'h0000, 8'h00, 8'h07);
    check(fi(7'h05), 8'hFF);
    $display("test erase done");
  endtask
  task automatic t_trim_hold();
    op(16'h8007, 8'h00, 8'h10);
    rd(16'hFF23);
    check(v, 8'hC4);
    op(16'h8007, 8'h99, 8'h01);
    check(bz, 8'h00);
    check(m(13'h0007), 8'hFF);
    // Hold output is one register behind the control bit
    wr(16'hFF20, 8'h80);
    @(posedge sys_clk);
    #1 check({7'h0, hold}, 8'h01);
    wr(16'hFF20, 8'h00);
    @(posedge sys_clk);
    #1 check({7'h0, hold}, 8'h00);
    $display("test trim and hold done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    reset = 1'b1;
    external_memory_space_wr = 1'b0;
    external_memory_space_rd = 1'b0;
    external_memory_space_addr = 16'h0000;
    external_memory_space_wdata = 8'h00;
    prog_addr = 16'h0000;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_prog();
    t_remap();
    t_auto();
    t_erase();
    t_trim_hold();
    summarize();
  end
endmodule
bind fiap_ctrl fiap_ctrl_asserts #(.CYC_PER_US(CYC_PER_US),
  .PROG_US(PROG_US), .ERASE_US(ERASE_US)) fiap_ctrl_asserts_i (.sys_clk,
  .reset, .external_memory_space_addr, .external_memory_space_wr, .external_memory_space_rd, .external_memory_space_wdata, .external_memory_space_rdata_q,
  .prog_addr, .prog_from_xram_q, .cpu_hold_in_reset_q, .cpu_stall_q,
  .flash_read_en_q, .flash_prog_en_q, .flash_sector_erase_q,
  .flash_mass_erase_q, .flash_info_sel_q, .flash_timing_sel_q);
